// *** dv/entry_table_model.sv ***
/* entry table model: remap entries as software leaves them in memory.
   assumes the bench picks one entry per request; entry 7 holds a random word. */
`timescale 1ns/1ps
module entry_table_model (
    input wire logic [2:0] idx, // entry the request references
    input wire logic [15:0] rnd_word, // contents given to entry 7
    output logic [15:0] entry_word // low word of the picked entry
);
    logic [15:0] ent_q [7];
    // valid only on fully built entries; 16'h001e is a stale one left unallocated
    initial ent_q = '{16'h0000, 16'h0002, 16'h0019, 16'h0041, 16'h0007, 16'h0025, 16'h001e};
    assign entry_word = (idx == 3'h7) ? rnd_word : ent_q[idx];
endmodule

// *** dv/test_remap_entry_low_field_decoder.sv ***
/* self-checking bench for the remap entry decoder.
   assumes one registered answer per request, one cycle after it is taken. */
`timescale 1ns/1ps
module test_remap_entry_low_field_decoder;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_fault = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [15:0] rnd_word = 16'h0000, entry_word;
    logic done_q, blocked_q, processed_q, single_target_q, fault_event_q;
    remap_entry_pkg::target_type target_q;
    logic [8:0] notes[$];
    logic [8:0] note;
    logic [31:0] rnd;
    int miscompares = 0, samples_checked = 0, seed = 32'ha0ef;
    always #10 clk = ~clk;
    entry_table_model entry_table_model_i (.idx(idx), .rnd_word(rnd_word), .entry_word(entry_word));
    remap_entry_low_field_decoder remap_entry_low_field_decoder_i (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .entry_word(entry_word), .req_fault(req_fault), .done_q(done_q),
        .blocked_q(blocked_q), .processed_q(processed_q), .target_q(target_q),
        .single_target_q(single_target_q), .fault_event_q(fault_event_q));
    ////////////////////////////////////////////////////////////////
    function automatic logic [8:0] expect_of(logic [15:0] w, logic f);
        logic [4:0] t;
        t = w[0] ? {w[4], w[2], w[3], w[7:5] == 3'h1, w[7:5] == 3'h0} : 5'h00;
        return {~w[0], w[0], t, w[0] & ~w[3], (~w[0] | f) & ~w[1]};
    endfunction
    task automatic cmp_flag(string nm, logic e, logic s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic cmp_target(logic [4:0] e, logic [4:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected target expected %h seen %h", e, s);
        end
    endtask
    task automatic send(logic v, logic [2:0] i, logic f);
        #1 req_valid = v;
        idx = i;
        req_fault = f & v;
        rnd_word = 16'($random(seed));
        @(posedge clk);
        if (v) notes.push_back(expect_of(entry_word, f & v));
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // answer lands one edge after the request, so a note pushed at an edge is due just after it
    always @(posedge clk) begin
        #2;
        if (done_q === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            cmp_flag("blocked", note[8], blocked_q);
            cmp_flag("processed", note[7], processed_q);
            cmp_target(note[6:2], target_q);
            cmp_flag("single", note[1], single_target_q);
            cmp_flag("fault", note[0], fault_event_q);
        end else if (notes.size() > 0) begin
            note = notes.pop_front();
            cmp_flag("done", 1'b1, done_q);
        end else begin
            cmp_flag("done", 1'b0, done_q);
            cmp_flag("blocked", 1'b0, blocked_q);
            cmp_flag("processed", 1'b0, processed_q);
            cmp_target(5'h00, target_q);
            cmp_flag("single", 1'b0, single_target_q);
            cmp_flag("fault", 1'b0, fault_event_q);
        end
    end
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        for (int i = 0; i < 16; i++) send(1'b1, i[2:0], i[3]);
        send(1'b0, 3'h0, 1'b0);
        $display("test table done");
        repeat (200) begin
            rnd = $random(seed);
            send(rnd[0] | rnd[5], rnd[3:1], rnd[4]);
        end
        send(1'b0, 3'h0, 1'b0);
        send(1'b0, 3'h0, 1'b0);
        $display("test random done");
        test_done();
    end
endmodule

// *** hdl/remap_entry_defs.svh ***
/*
 * bit positions and encodings of the low control fields of one remap table entry.
 * assumes entries arrive as a 16-bit low word, bit 0 first.
 */
`ifndef REMAP_ENTRY_DEFS_SVH
`define REMAP_ENTRY_DEFS_SVH

`define ENTRY_VALID_POS 0
`define FAULT_SUPPRESS_POS 1
`define DEST_INTERP_POS 2
`define REDIR_HINT_POS 3
`define TRIGGER_TYPE_POS 4
`define DELIVERY_LO_POS 5
`define DELIVERY_HI_POS 7
`define DELIVERY_ALL 3'h0
`define DELIVERY_ONE 3'h1

`endif

// *** hdl/remap_entry_low_field_decoder.sv ***
/*
 * decoder for the low control fields of a remap table entry: block or process,
 * targeting, fault reporting.
 * assumes one request per cycle from logic on clk, entry word valid alongside it.
 */
`timescale 1ns/1ps
`include "remap_entry_defs.svh"

module remap_entry_low_field_decoder #(
    parameter int ENTRY_W = 16
) (
    input wire logic clk,                       // 50 MHz clock
    input wire logic rst_n,                     // async reset, active low
    input wire logic req_valid,                 // request referencing entry
    input wire logic [ENTRY_W-1:0] entry_word,  // low word of the entry
    input wire logic req_fault,                 // other fault seen on this request
    output logic done_q,                        // pulse: decision ready
    output logic blocked_q,                     // request blocked
    output logic processed_q,                   // request passed on
    output remap_entry_pkg::target_type target_q, // targeting of passed request
    output logic single_target_q,               // directed to the named processor
    output logic fault_event_q                  // pulse: fault recorded and reported
);

    ////////////////////////////////////////////////////////////////////////////
    wire logic valid_bit = entry_word[`ENTRY_VALID_POS];
    wire logic fault_suppression_bit = entry_word[`FAULT_SUPPRESS_POS];
    wire logic destination_interpretation_bit = entry_word[`DEST_INTERP_POS];
    wire logic redirection_hint_bit = entry_word[`REDIR_HINT_POS];
    wire logic trigger_type_bit = entry_word[`TRIGGER_TYPE_POS];
    wire logic [2:0] delivery_kind_field = entry_word[`DELIVERY_HI_POS:`DELIVERY_LO_POS];

    wire logic block_now = req_valid && !valid_bit;
    wire logic pass_now = req_valid && valid_bit;
    // suppression read regardless of the valid check, so unallocated entries with it set stay quiet
    wire logic fault_now = req_valid && (block_now || req_fault) && !fault_suppression_bit;

    // fields masked by valid so stale garbage never leaks out
    remap_entry_pkg::target_type target_d;
    assign target_d.level_trigger = pass_now && trigger_type_bit;
    assign target_d.logical_dest = pass_now && destination_interpretation_bit;
    assign target_d.redirect = pass_now && redirection_hint_bit;
    assign target_d.deliver_all = pass_now && (delivery_kind_field == `DELIVERY_ALL);
    assign target_d.deliver_one = pass_now && (delivery_kind_field == `DELIVERY_ONE);
    wire logic single_d = pass_now && !redirection_hint_bit;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            blocked_q <= 1'b0;
            processed_q <= 1'b0;
            target_q <= '0;
            single_target_q <= 1'b0;
            fault_event_q <= 1'b0;
        end else begin
            done_q <= req_valid;
            blocked_q <= block_now;
            processed_q <= pass_now;
            target_q <= target_d;
            single_target_q <= single_d;
            fault_event_q <= fault_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decision: exactly one answer per request, one cycle after it is taken
    property p_block;
        @(posedge clk) disable iff (!rst_n)
            req_valid && !valid_bit |=> blocked_q && !processed_q;
    endproperty
    a_block: assert property (p_block) else $error("invalid entry not blocked");

    property p_pass;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit |=> processed_q && !blocked_q;
    endproperty
    a_pass: assert property (p_pass) else $error("valid entry not processed");

    property p_done;
        @(posedge clk) disable iff (!rst_n)
            req_valid |=> done_q;
    endproperty
    a_done: assert property (p_done) else $error("request not answered");

    property p_quiet;
        @(posedge clk) disable iff (!rst_n)
            !req_valid |=> !done_q && !blocked_q && !processed_q && !fault_event_q;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");

    property p_one_way;
        @(posedge clk) disable iff (!rst_n)
            done_q |-> blocked_q != processed_q;
    endproperty
    a_one_way: assert property (p_one_way) else $error("answer neither or both");

    ////////////////////////////////////////////////////////////////////////////
    // targeting: only a processed request may carry fields
    property p_trig;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit |=> target_q.level_trigger == $past(trigger_type_bit);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger type wrong");

    property p_ignore;
        @(posedge clk) disable iff (!rst_n)
            !processed_q |-> !target_q.level_trigger && !target_q.redirect && !target_q.logical_dest;
    endproperty
    a_ignore: assert property (p_ignore) else $error("fields used on invalid entry");

    property p_blank_target;
        @(posedge clk) disable iff (!rst_n)
            req_valid && !valid_bit |=> target_q == '0 && !single_target_q;
    endproperty
    a_blank_target: assert property (p_blank_target) else $error("blocked request carries target");

    property p_idle_target;
        @(posedge clk) disable iff (!rst_n)
            !done_q |-> target_q == '0 && !single_target_q;
    endproperty
    a_idle_target: assert property (p_idle_target) else $error("target without answer");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
            processed_q |-> single_target_q != target_q.redirect;
    endproperty
    a_single: assert property (p_single) else $error("hint targeting wrong");

    property p_direct;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && !redirection_hint_bit |=> single_target_q && !target_q.redirect;
    endproperty
    a_direct: assert property (p_direct) else $error("named processor not targeted");

    property p_hint_one;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && redirection_hint_bit |=> !single_target_q;
    endproperty
    a_hint_one: assert property (p_hint_one) else $error("hint ignored");

    property p_single_owned;
        @(posedge clk) disable iff (!rst_n)
            single_target_q |-> processed_q;
    endproperty
    a_single_owned: assert property (p_single_owned) else $error("single target on blocked request");

    property p_redir;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && redirection_hint_bit |=> target_q.redirect;
    endproperty
    a_redir: assert property (p_redir) else $error("redirect missing");

    property p_dest;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit |=> target_q.logical_dest == $past(destination_interpretation_bit);
    endproperty
    a_dest: assert property (p_dest) else $error("destination interpretation wrong");

    property p_kind;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && delivery_kind_field == `DELIVERY_ONE
            |=> target_q.deliver_one && !target_q.deliver_all;
    endproperty
    a_kind: assert property (p_kind) else $error("delivery kind wrong");

    property p_kind_all;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && delivery_kind_field == `DELIVERY_ALL
            |=> target_q.deliver_all && !target_q.deliver_one;
    endproperty
    a_kind_all: assert property (p_kind_all) else $error("delivery to all wrong");

    // other kinds are left to later stages, so both flags stay low
    property p_kind_other;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && delivery_kind_field > `DELIVERY_ONE
            |=> !target_q.deliver_all && !target_q.deliver_one;
    endproperty
    a_kind_other: assert property (p_kind_other) else $error("unknown delivery kind flagged");

    ////////////////////////////////////////////////////////////////////////////
    property p_report;
        @(posedge clk) disable iff (!rst_n)
            req_valid && !fault_suppression_bit && (!valid_bit || req_fault) |=> fault_event_q;
    endproperty
    a_report: assert property (p_report) else $error("fault not reported");

    property p_suppress;
        @(posedge clk) disable iff (!rst_n)
            req_valid && fault_suppression_bit |=> !fault_event_q;
    endproperty
    a_suppress: assert property (p_suppress) else $error("suppressed fault reported");

    property p_clean_pass;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && !req_fault |=> !fault_event_q;
    endproperty
    a_clean_pass: assert property (p_clean_pass) else $error("fault raised on clean request");

    property p_pass_report;
        @(posedge clk) disable iff (!rst_n)
            req_valid && valid_bit && req_fault && !fault_suppression_bit |=> fault_event_q && processed_q;
    endproperty
    a_pass_report: assert property (p_pass_report) else $error("fault on processed request lost");

    property p_block_quiet;
        @(posedge clk) disable iff (!rst_n)
            req_valid && !valid_bit && fault_suppression_bit |=> blocked_q && !fault_event_q;
    endproperty
    a_block_quiet: assert property (p_block_quiet) else $error("suppressed block reported");

    property p_event_owned;
        @(posedge clk) disable iff (!rst_n)
            fault_event_q |-> done_q;
    endproperty
    a_event_owned: assert property (p_event_owned) else $error("fault event without request");

endmodule

// *** hdl/remap_entry_pkg.sv ***
/*
 * types shared by the remap entry decoder.
 * assumes remap_entry_defs.svh holds the field positions.
 */
package remap_entry_pkg;
    typedef struct packed {
        logic level_trigger;   // 1 level, 0 edge
        logic logical_dest;    // 1 logical id, 0 physical id
        logic redirect;        // 1 pick one of n processors
        logic deliver_one;     // delivery kind picks one agent
        logic deliver_all;     // delivery kind names all agents
    } target_type;
endpackage
